// [hw/lfs_pkg.sv]
package lfs_pkg;
    localparam int NUM_CH = 6;
    // channel time-out in pwm dimming periods
    localparam logic [2:0] CH_TIMEOUT_PERIODS = 3'h6;
    // current scale steps: full, then reduced per thermal trip
    localparam logic [7:0] SCALE_FULL = 8'h64;
    localparam logic [7:0] SCALE_FIRST = 8'h4c;
    localparam logic [7:0] SCALE_STEP = 8'h0a;
    localparam logic [7:0] SCALE_MIN = 8'h0a;
    // status field positions
    localparam int ST_FAULT = 0;
    localparam int ST_THERMAL = 1;
    localparam int ST_OVCURR = 2;
    localparam int ST_BL_ON = 3;
    localparam int ST_ONE_OFF = 4;
    localparam int ST_TWO_OFF = 5;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    typedef enum logic [2:0] {
        LFS_OFF,
        LFS_PRECHECK,
        LFS_RUN,
        LFS_HOT,
        LFS_LATCHED
    } lfs_state_type;
endpackage

// [hw/lfs_chan_timer.sv]
module lfs_chan_timer
    import lfs_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic reset,
    // control
    input wire logic run,
    input wire logic pwm_period,
    input wire logic faulted,
    input wire logic at_target,
    input wire logic host_enable,
    // result
    output logic off
);
    logic [2:0] cnt_q;
    logic [2:0] cnt_d;
    logic off_q;
    wire expire = pwm_period && faulted && (cnt_q == CH_TIMEOUT_PERIODS - 3'h1);
    // counter clears on reaching target, counts periods while faulted
    assign cnt_d = (!run || at_target || !faulted) ? 3'h0 : (pwm_period ? cnt_q + 3'h1 : cnt_q);
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            cnt_q <= 3'h0;
            off_q <= 1'b0;
        end
        else
        begin
            cnt_q <= off_q ? 3'h0 : cnt_d;
            off_q <= !host_enable ? 1'b0 : (off_q || (run && expire));
        end
    end
    assign off = off_q;
endmodule

// [hw/lfs_core.sv]
module lfs_core
    import lfs_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic reset,
    // mode and enable
    input wire logic bus_mode,
    input wire logic enable_pin,
    input wire logic host_enable,
    // analog comparators
    input wire logic supply_lockout,
    input wire logic switch_over_limit,
    input wire logic cycle_start,
    input wire logic switch_node_ok,
    input wire logic output_overvolt_sense,
    input wire logic output_fifth_above,
    input wire logic temp_lower,
    input wire logic temp_upper,
    input wire logic switch_node_short,
    // channel sense
    input wire logic pwm_period,
    input wire logic [NUM_CH-1:0] ch_at_target,
    input wire logic [NUM_CH-1:0] ch_short_sense,
    // power stage
    output logic boost_switch_on,
    output logic test_current_on,
    output logic input_fet_on,
    output logic [NUM_CH-1:0] ch_enable,
    output logic [7:0] current_scale,
    // host status
    output logic [7:0] fault_status,
    output logic status_valid
);
    lfs_state_type state_q;
    lfs_state_type state_d;
    logic fifth_seen_q;
    logic in_limit_q;
    logic switch_q;
    logic fet_q;
    logic test_q;
    logic thermal_q;
    logic ovcurr_q;
    logic [7:0] scale_q;
    logic [NUM_CH-1:0] chen_q;
    logic [7:0] status_q;
    logic valid_q;
    logic [NUM_CH-1:0] ch_off;
    logic [2:0] off_count;

    wire lockout = supply_lockout || !enable_pin;
    wire running = (state_q == LFS_RUN);
    wire go_enable = bus_mode ? host_enable : enable_pin;
    wire fifth_fall = fifth_seen_q && !output_fifth_above;
    wire hard_short = switch_node_short || fifth_fall;
    wire open_scan = temp_lower || output_overvolt_sense;
    wire [7:0] scale_next = (scale_q == SCALE_FULL) ? SCALE_FIRST :
        ((scale_q > SCALE_MIN + SCALE_STEP) ? scale_q - SCALE_STEP : SCALE_MIN);

    // per-channel open and short time-outs
    genvar gi;
    generate
        for (gi = 0; gi < NUM_CH; gi++)
        begin : g_ch
            wire ch_fault = ch_short_sense[gi] || (open_scan && !ch_at_target[gi]);
            lfs_chan_timer u_timer (
                .clock(clock),
                .reset(reset),
                .run(running),
                .pwm_period(pwm_period),
                .faulted(ch_fault),
                .at_target(ch_at_target[gi] && !ch_short_sense[gi]),
                .host_enable(go_enable),
                .off(ch_off[gi])
            );
        end
    endgenerate

    always_comb
    begin
        off_count = 3'h0;
        for (int i = 0; i < NUM_CH; i++)
        begin
            off_count = off_count + {2'h0, ch_off[i]};
        end
    end

    // state sequencing
    always_comb
    begin
        state_d = state_q;
        unique case (state_q)
            LFS_OFF:
            begin
                if (go_enable)
                begin
                    state_d = LFS_PRECHECK;
                end
            end
            LFS_PRECHECK:
            begin
                if (switch_node_ok)
                begin
                    state_d = LFS_RUN;
                end
            end
            LFS_RUN:
            begin
                if (temp_upper)
                begin
                    state_d = LFS_HOT;
                end
            end
            LFS_HOT:
            begin
                if (!temp_upper && !temp_lower)
                begin
                    state_d = LFS_RUN;
                end
            end
            LFS_LATCHED:
            begin
                state_d = LFS_LATCHED;
            end
            default:
            begin
                state_d = LFS_OFF;
            end
        endcase
        if (hard_short && state_q != LFS_OFF)
        begin
            state_d = LFS_LATCHED;
        end
    end

    // bus-mode lockout waits for a fresh host enable
    logic need_reenable_q;

    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            state_q <= LFS_OFF;
            need_reenable_q <= 1'b0;
        end
        else if (lockout)
        begin
            state_q <= LFS_OFF;
            need_reenable_q <= bus_mode;
        end
        else if (need_reenable_q)
        begin
            need_reenable_q <= host_enable;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    // fifth-level tracking and cycle current limit
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            fifth_seen_q <= 1'b0;
            in_limit_q <= 1'b0;
        end
        else if (lockout)
        begin
            fifth_seen_q <= 1'b0;
            in_limit_q <= 1'b0;
        end
        else
        begin
            fifth_seen_q <= fifth_seen_q || output_fifth_above;
            in_limit_q <= cycle_start ? 1'b0 : (in_limit_q || switch_over_limit);
        end
    end

    // power stage drives
    wire switch_d = running && !switch_over_limit && !(in_limit_q && !cycle_start) && !temp_upper;
    wire fet_d = (state_q != LFS_OFF) && (state_q != LFS_LATCHED) && !hard_short;
    wire [NUM_CH-1:0] chen_d = (running && !temp_upper) ? ~ch_off : '0;

    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            switch_q <= 1'b0;
            fet_q <= 1'b0;
            test_q <= 1'b0;
            chen_q <= '0;
        end
        else
        begin
            switch_q <= switch_d && !lockout;
            fet_q <= fet_d && !lockout;
            test_q <= (state_q == LFS_PRECHECK) && !lockout;
            chen_q <= lockout ? '0 : chen_d;
        end
    end

    // thermal derating and fault flags
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            scale_q <= SCALE_FULL;
            thermal_q <= 1'b0;
            ovcurr_q <= 1'b0;
        end
        else if (lockout)
        begin
            scale_q <= SCALE_FULL;
            thermal_q <= 1'b0;
            ovcurr_q <= 1'b0;
        end
        else
        begin
            if (running && temp_upper)
            begin
                scale_q <= scale_next;
            end
            thermal_q <= thermal_q || temp_upper;
            ovcurr_q <= ovcurr_q || hard_short;
        end
    end

    // status image for host reads
    wire [7:0] status_d = {2'h0, off_count >= 3'h2, off_count == 3'h1, running,
        ovcurr_q, thermal_q, thermal_q || ovcurr_q || (|ch_off)};

    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            status_q <= STATUS_RESET;
            valid_q <= 1'b0;
        end
        else
        begin
            status_q <= enable_pin ? status_d : STATUS_RESET;
            valid_q <= enable_pin;
        end
    end

    assign boost_switch_on = switch_q;
    assign test_current_on = test_q;
    assign input_fet_on = fet_q;
    assign ch_enable = chen_q;
    assign current_scale = scale_q;
    assign fault_status = status_q;
    assign status_valid = valid_q;

    // checks
    AST_LOCKOUT_STOPS: assert property (@(posedge clock) disable iff (reset)
        supply_lockout |=> !boost_switch_on && ch_enable == '0)
        else $error("switching continued under supply lockout");
    sequence limit_hit_seq;
        switch_over_limit && !cycle_start ##1 !cycle_start;
    endsequence
    AST_LIMIT_CYCLE: assert property (@(posedge clock) disable iff (reset)
        limit_hit_seq |=> !boost_switch_on)
        else $error("switch on after current limit in same cycle");
    AST_PRECHECK: assert property (@(posedge clock) disable iff (reset)
        state_q == LFS_PRECHECK |-> !boost_switch_on)
        else $error("switching before switch node check");
    AST_HOT_OFF: assert property (@(posedge clock) disable iff (reset)
        temp_upper |=> !boost_switch_on && ch_enable == '0)
        else $error("outputs on during upper thermal trip");
    AST_THERMAL_FLAG: assert property (@(posedge clock) disable iff (reset)
        temp_upper && !lockout |=> ##1 fault_status[ST_THERMAL])
        else $error("thermal flag not set");
    AST_SUMMARY: assert property (@(posedge clock) disable iff (reset)
        fault_status[ST_FAULT] == (fault_status[ST_THERMAL] || fault_status[ST_OVCURR] ||
        fault_status[ST_ONE_OFF] || fault_status[ST_TWO_OFF]))
        else $error("summary flag mismatch");
    AST_LATCH: assert property (@(posedge clock) disable iff (reset || lockout)
        state_q == LFS_LATCHED |=> state_q == LFS_LATCHED && !input_fet_on)
        else $error("left permanent shutdown");
    AST_DERATE: assert property (@(posedge clock) disable iff (reset || lockout)
        running && temp_upper && scale_q == SCALE_FULL |=> current_scale == SCALE_FIRST)
        else $error("first derate not 76 percent");
    AST_VALID: assert property (@(posedge clock) disable iff (reset)
        enable_pin |=> status_valid)
        else $error("status not readable while enabled");
    sequence fifth_rise_fall_seq;
        output_fifth_above ##1 !output_fifth_above;
    endsequence
    AST_FIFTH_FALL: assert property (@(posedge clock) disable iff (reset || lockout)
        fifth_rise_fall_seq ##0 (state_q != LFS_OFF) |=> state_q == LFS_LATCHED && !input_fet_on)
        else $error("input transistor stayed on after fifth-level fall");
    sequence short_seen_seq;
        hard_short && (state_q != LFS_OFF) && !lockout;
    endsequence
    AST_SHORT_LATCH: assert property (@(posedge clock) disable iff (reset)
        short_seen_seq |=> state_q == LFS_LATCHED && !input_fet_on)
        else $error("short to ground did not latch off");
    AST_TEST_CURRENT: assert property (@(posedge clock) disable iff (reset)
        state_q == LFS_PRECHECK && !lockout |=> test_current_on)
        else $error("no test current during start check");
    AST_REENABLE: assert property (@(posedge clock) disable iff (reset)
        need_reenable_q |-> state_q == LFS_OFF)
        else $error("started before host re-enable");
    AST_OFF_FLAGS: assert property (@(posedge clock) disable iff (reset)
        (|ch_off) && enable_pin |=> fault_status[ST_ONE_OFF] || fault_status[ST_TWO_OFF])
        else $error("channel off not reported");
    AST_HOT_HOLD: assert property (@(posedge clock) disable iff (reset)
        state_q == LFS_HOT |-> ch_enable == '0 && !boost_switch_on)
        else $error("channels on before cooling");
    AST_RESUME: assert property (@(posedge clock) disable iff (reset)
        state_q == LFS_HOT && !temp_upper && !temp_lower && !lockout && !hard_short |=> state_q == LFS_RUN)
        else $error("no resume after cooling");
    AST_CH_FOLLOW: assert property (@(posedge clock) disable iff (reset)
        running && !temp_upper && !lockout |=> ch_enable == ~$past(ch_off))
        else $error("channel enable does not follow time-outs");
    AST_DERATE_STEP: assert property (@(posedge clock) disable iff (reset)
        running && temp_upper && scale_q != SCALE_FULL && !lockout |=> current_scale == $past(scale_q) - SCALE_STEP || current_scale == SCALE_MIN)
        else $error("further trip did not reduce current");
    AST_LOCKOUT_SCALE: assert property (@(posedge clock) disable iff (reset)
        lockout |=> current_scale == SCALE_FULL && state_q == LFS_OFF)
        else $error("lockout did not reset control state");
endmodule

// [sim/lfs_host_model.sv]
module lfs_host_model
    import lfs_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic reset,
    // bench request
    input wire logic want_on,
    // device side
    input wire logic [7:0] fault_status,
    input wire logic status_valid,
    output logic host_enable,
    output logic [7:0] last_status
);
    timeunit 1ns;
    timeprecision 1ns;
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            host_enable <= 1'b0;
            last_status <= STATUS_RESET;
        end
        else
        begin
            host_enable <= want_on;
            if (status_valid)
            begin
                last_status <= fault_status;
            end
        end
    end
endmodule

// [sim/led_driver_fault_supervisor_bench.sv]
module led_driver_fault_supervisor_bench;
    timeunit 1ns;
    timeprecision 1ns;
    import lfs_pkg::*;
    logic clock = 1'b0;
    logic reset = 1'b1;
    logic bus_mode = 1'b0, enable_pin = 1'b0, want_on = 1'b0, supply_lockout = 1'b0;
    logic switch_over_limit = 1'b0, cycle_start = 1'b0, switch_node_ok = 1'b0, output_overvolt_sense = 1'b0;
    logic output_fifth_above = 1'b0, temp_lower = 1'b0, temp_upper = 1'b0, switch_node_short = 1'b0;
    logic pwm_period = 1'b0;
    logic [NUM_CH-1:0] ch_at_target = 6'h3f, ch_short_sense = 6'h00, ch_enable;
    logic boost_switch_on, test_current_on, input_fet_on, host_enable, status_valid;
    logic [7:0] current_scale, fault_status, last_status;
    int err_count = 0;
    int check_count = 0;
    int unsigned rng = 44208;

    lfs_core DUT (.clock(clock), .reset(reset), .bus_mode(bus_mode), .enable_pin(enable_pin),
        .host_enable(host_enable), .supply_lockout(supply_lockout), .switch_over_limit(switch_over_limit),
        .cycle_start(cycle_start), .switch_node_ok(switch_node_ok), .output_overvolt_sense(output_overvolt_sense),
        .output_fifth_above(output_fifth_above), .temp_lower(temp_lower), .temp_upper(temp_upper),
        .switch_node_short(switch_node_short), .pwm_period(pwm_period), .ch_at_target(ch_at_target),
        .ch_short_sense(ch_short_sense), .boost_switch_on(boost_switch_on), .test_current_on(test_current_on),
        .input_fet_on(input_fet_on), .ch_enable(ch_enable), .current_scale(current_scale),
        .fault_status(fault_status), .status_valid(status_valid));

    lfs_host_model host (.clock(clock), .reset(reset), .want_on(want_on), .fault_status(fault_status),
        .status_valid(status_valid), .host_enable(host_enable), .last_status(last_status));

    function automatic int unsigned next_rand();
        rng = rng ^ (rng << 13);
        rng = rng ^ (rng >> 17);
        rng = rng ^ (rng << 5);
        return rng;
    endfunction

    // derated current after a number of upper thermal trips
    function automatic logic [7:0] expected_scale(input int trips);
        int v;
        if (trips == 0)
            return SCALE_FULL;
        v = int'(SCALE_FIRST) - int'(SCALE_STEP) * (trips - 1);
        if (v < int'(SCALE_MIN))
            v = int'(SCALE_MIN);
        return v[7:0];
    endfunction

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            err_count++;
            $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic report_and_stop();
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        @(negedge clock);
    endtask

    task automatic wait_run();
        int i;
        for (i = 0; i < 50 && boost_switch_on !== 1'b1; i++)
            tick(1);
        if (boost_switch_on !== 1'b1)
        begin
            err_count++;
            $display("ERROR t=%0t switching never started", $time);
            report_and_stop();
        end
    endtask

    task automatic pulses(input int n);
        repeat (n)
        begin
            @(posedge clock) pwm_period <= 1'b1;
            @(posedge clock) pwm_period <= 1'b0;
            repeat (next_rand() % 4) @(posedge clock);
        end
        tick(2);
    endtask

    // drop and raise the enable pin to clear channel flags
    task automatic restart();
        @(posedge clock) enable_pin <= 1'b0;
        tick(3);
        check(8'(status_valid), 8'h00);
        @(posedge clock) enable_pin <= 1'b1;
        wait_run();
    endtask

    initial
    begin
        forever #50 clock = ~clock;
    end

    initial
    begin
        int i;
        int c;
        int k;
        logic [NUM_CH-1:0] m;
        tick(7);
        check(current_scale, SCALE_FULL);
        check(8'({boost_switch_on, test_current_on, ch_enable}), 8'h00);
        @(posedge clock) reset <= 1'b0;
        // start-up test current, switching held off
        @(posedge clock) enable_pin <= 1'b1;
        tick(10);
        check(8'({test_current_on, boost_switch_on}), 8'h02);
        @(posedge clock) switch_node_ok <= 1'b1;
        wait_run();
        check(8'({input_fet_on, ch_enable}), 8'h7f);
        // current limit ends the cycle
        @(posedge clock) switch_over_limit <= 1'b1;
        tick(2);
        check(8'(boost_switch_on), 8'h00);
        @(posedge clock) switch_over_limit <= 1'b0;
        cycle_start <= 1'b1;
        @(posedge clock) cycle_start <= 1'b0;
        tick(2);
        check(8'(boost_switch_on), 8'h01);
        // short and overvoltage on a random channel, lower thermal on two adjacent channels
        for (c = 0; c < 3; c++)
        begin
            k = next_rand() % NUM_CH;
            m = ~(6'h01 << k);
            if (c == 1)
                m = m & ~(6'h01 << ((k + 1) % NUM_CH));
            @(posedge clock) ch_short_sense <= (c == 0) ? ~m : 6'h00;
            ch_at_target <= (c == 0) ? 6'h3f : m;
            temp_lower <= (c == 1);
            output_overvolt_sense <= (c == 2);
            pulses(5);
            check(8'(ch_enable), 8'h3f);
            pulses(1);
            check(8'(ch_enable), 8'(m));
            tick(3);
            check(8'(last_status[ST_TWO_OFF:ST_ONE_OFF]), (c == 1) ? 8'h02 : 8'h01);
            @(posedge clock) ch_short_sense <= 6'h00;
            ch_at_target <= 6'h3f;
            temp_lower <= 1'b0;
            output_overvolt_sense <= 1'b0;
            restart();
        end
        // repeated upper thermal trips
        for (i = 1; i <= 2; i++)
        begin
            @(posedge clock) temp_upper <= 1'b1;
            tick(2);
            check(8'({boost_switch_on, ch_enable}), 8'h00);
            tick(3);
            check(last_status & 8'h03, 8'h03);
            check(8'(status_valid), 8'h01);
            @(posedge clock) temp_upper <= 1'b0;
            wait_run();
            check(current_scale, expected_scale(i));
        end
        // lockout in automatic mode
        @(posedge clock) supply_lockout <= 1'b1;
        tick(2);
        check(8'({boost_switch_on, ch_enable}), 8'h00);
        check(current_scale, SCALE_FULL);
        @(posedge clock) supply_lockout <= 1'b0;
        wait_run();
        // lockout under host control
        @(posedge clock) want_on <= 1'b1;
        tick(2);
        @(posedge clock) bus_mode <= 1'b1;
        tick(2);
        @(posedge clock) supply_lockout <= 1'b1;
        tick(2);
        @(posedge clock) supply_lockout <= 1'b0;
        tick(20);
        check(8'(boost_switch_on), 8'h00);
        @(posedge clock) want_on <= 1'b0;
        tick(3);
        @(posedge clock) want_on <= 1'b1;
        wait_run();
        // short to ground latches off
        @(posedge clock) switch_node_short <= 1'b1;
        tick(2);
        @(posedge clock) switch_node_short <= 1'b0;
        want_on <= 1'b0;
        tick(3);
        @(posedge clock) want_on <= 1'b1;
        tick(20);
        check(8'({boost_switch_on, test_current_on, ch_enable}), 8'h00);
        check(last_status & 8'h0f, 8'h05);
        // rise then fall of the fifth-level sense latches off
        @(posedge clock) supply_lockout <= 1'b1;
        want_on <= 1'b0;
        tick(2);
        @(posedge clock) supply_lockout <= 1'b0;
        tick(3);
        @(posedge clock) want_on <= 1'b1;
        wait_run();
        check(8'(input_fet_on), 8'h01);
        @(posedge clock) output_fifth_above <= 1'b1;
        tick(2);
        @(posedge clock) output_fifth_above <= 1'b0;
        tick(3);
        check(8'({input_fet_on, boost_switch_on, ch_enable}), 8'h00);
        report_and_stop();
    end
endmodule
